/* shared/usbev_pkg.sv */
package usbev_pkg;
   localparam int unsigned AW = 8;
   localparam int unsigned DW = 8;

   // register offsets
   localparam logic [7:0] OFF_HUB_EN    = 8'h00;
   localparam logic [7:0] OFF_HUB_FLAGS = 8'h01;
   localparam logic [7:0] OFF_HUB_FSET  = 8'h02;
   localparam logic [7:0] OFF_HUB_FCLR  = 8'h03;
   localparam logic [7:0] OFF_IEN_ZERO  = 8'h04;
   localparam logic [7:0] OFF_IEN_ONE   = 8'h05;
   localparam logic [7:0] OFF_PWR_CTL   = 8'h06;

   // field positions
   localparam int unsigned B_TX_DONE = 0;
   localparam int unsigned B_RX_DONE = 1;
   localparam int unsigned B_GIE     = 7;
   localparam int unsigned B_EXT_EN  = 0;
   localparam int unsigned B_EXT_LVL = 1;
   localparam int unsigned B_SR_EN   = 2;
   localparam int unsigned B_EXT_PRI = 3;
   localparam int unsigned B_SUS     = 0;
   localparam int unsigned B_RSM     = 1;
   localparam int unsigned B_RWU     = 2;
   localparam int unsigned B_PD      = 3;

   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [1:0] RST_PAIR = 2'h0;

   // timing
   localparam int unsigned CLK_HZ     = 40_000_000;
   localparam int unsigned SUSPEND_MS = 3;
   localparam int unsigned RESUME_MS  = 20;
   localparam int unsigned SUSPEND_CYC = SUSPEND_MS * (CLK_HZ / 1000);
   localparam int unsigned RESUME_CYC  = RESUME_MS * (CLK_HZ / 1000);

   typedef enum logic [2:0] {
      PWR_RUN  = 3'b001,
      PWR_SUSP = 3'b010,
      PWR_DOWN = 3'b100
   } usbev_pwr_t;
endpackage

/* shared/usbev_link_if.sv */
interface usbev_link_if;
   logic busActive;
   logic resumeK;
   logic wakeK;

   modport dev (
      input  busActive,
      input  resumeK,
      output wakeK
   );

   modport up (
      output busActive,
      output resumeK,
      input  wakeK
   );
endinterface

/* hw/usbev_idle_timer.sv */
// one pulse when the bus has been idle longer than IDLE_CYC cycles
module usbev_idle_timer #(
   parameter int unsigned IDLE_CYC = usbev_pkg::SUSPEND_CYC
) (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic busActive,
   output logic      idlePulse
);
   localparam int unsigned CW = $clog2(IDLE_CYC + 2);
   localparam logic [CW-1:0] LIMIT = CW'(IDLE_CYC);

   if (IDLE_CYC < 2)
   begin : g_chk
      $error("IDLE_CYC too small");
   end

   logic [CW-1:0] cnt_r;
   logic          fired_r;
   wire           over = (cnt_r >= LIMIT);

   always_ff @(posedge clk)
   begin
      if (srst || busActive)
      begin
         cnt_r   <= '0;
         fired_r <= 1'b0;
      end
      else if (!over)
         cnt_r <= cnt_r + 1'b1;
      else
         fired_r <= 1'b1;
   end

   // fires once per idle stretch, in the same cycle the count reaches the limit
   assign idlePulse = over && !fired_r && !busActive;
endmodule

/* hw/usbev_dev_end.sv */
// Decided for this implementation: the strobed register port and the placing of the registers.
module usbev_dev_end #(
   parameter int unsigned IDLE_CYC = usbev_pkg::SUSPEND_CYC
) (
   input  wire logic       clk,
   input  wire logic       srst,
   usbev_link_if.dev       link,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic [7:0]      rdata,
   input  wire logic       rxDoneEvt,
   input  wire logic       rxFifoErr,
   input  wire logic       txAckEvt,
   input  wire logic       txFifoErr,
   input  wire logic       sofIrq,
   input  wire logic       extIntLvl,
   output logic            hubSofIrq,
   output logic            susResIrq,
   output logic            extIrq,
   output logic            coreClkRun,
   output logic            busSuspended
);
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   logic [1:0]          hubEn_r;
   logic [1:0]          hubFlag_r;
   logic [1:0]          hubFlag_nxt;
   logic                gie_r;
   logic                srEn_r;
   logic                extEn_r;
   logic                extLvl_r;
   logic                extPri_r;
   logic                susFlag_r;
   logic                rsmFlag_r;
   logic                rwu_r;
   logic [7:0]          rdata_r;
   logic                hubSofIrq_r;
   logic                susResIrq_r;
   logic                extIrq_r;
   logic                clkRun_r;
   logic                susp_r;
   usbev_pkg::usbev_pwr_t pwr_r;
   usbev_pkg::usbev_pwr_t pwr_nxt;
   logic                idlePulse;

   // decode
   wire wrHubEn  = wr && hit(addr, usbev_pkg::OFF_HUB_EN);
   wire wrFlags  = wr && hit(addr, usbev_pkg::OFF_HUB_FLAGS);
   wire wrFset   = wr && hit(addr, usbev_pkg::OFF_HUB_FSET);
   wire wrFclr   = wr && hit(addr, usbev_pkg::OFF_HUB_FCLR);
   wire wrIen0   = wr && hit(addr, usbev_pkg::OFF_IEN_ZERO);
   wire wrIen1   = wr && hit(addr, usbev_pkg::OFF_IEN_ONE);
   wire wrPwr    = wr && hit(addr, usbev_pkg::OFF_PWR_CTL);
   wire [1:0] wLow = wdata[1:0];

   // endpoint 0 event sources only
   wire rxSet = rxDoneEvt || rxFifoErr;
   wire txSet = txAckEvt || txFifoErr;
   wire [1:0] hwSet = {rxSet, txSet};

   // software write stores, alias set/clear per bit, hardware set wins
   wire [1:0] swFlag = wrFlags ? wLow :
                       wrFset  ? (hubFlag_r | wLow) :
                       wrFclr  ? (hubFlag_r & ~wLow) :
                                 hubFlag_r;
   assign hubFlag_nxt = swFlag | hwSet;

   wire hubReq = gie_r && |(hubFlag_r & hubEn_r);
   wire extReq = extEn_r && extLvl_r && extIntLvl;
   // a higher-priority external request holds off the shared one
   wire srMask = extReq && extPri_r;
   wire srReq  = gie_r && srEn_r && (susFlag_r || rsmFlag_r) && !srMask;

   wire suspEvt = idlePulse && !susp_r;
   wire rsmEvt  = susp_r && link.resumeK;
   wire pdReq   = wrPwr && wdata[usbev_pkg::B_PD];

   // power sequencing
   always_comb
   begin
      pwr_nxt = pwr_r;
      unique case (pwr_r)
         usbev_pkg::PWR_RUN:
         begin
            if (pdReq)
               pwr_nxt = usbev_pkg::PWR_DOWN;
            else if (suspEvt)
               pwr_nxt = usbev_pkg::PWR_SUSP;
         end
         usbev_pkg::PWR_SUSP:
         begin
            if (link.resumeK || link.busActive)
               pwr_nxt = usbev_pkg::PWR_RUN;
            else if (pdReq)
               pwr_nxt = usbev_pkg::PWR_DOWN;
         end
         usbev_pkg::PWR_DOWN:
         begin
            // state is held, not reset, so execution picks up where it stopped
            if (link.resumeK || extReq)
               pwr_nxt = usbev_pkg::PWR_RUN;
         end
         default:
            pwr_nxt = usbev_pkg::PWR_RUN;
      endcase
   end

   wire [7:0] rdSel =
      hit(addr, usbev_pkg::OFF_HUB_EN)    ? {6'h00, hubEn_r} :
      hit(addr, usbev_pkg::OFF_HUB_FLAGS) ? {6'h00, hubFlag_r} :
      hit(addr, usbev_pkg::OFF_HUB_FSET)  ? {6'h00, hubFlag_r} :
      hit(addr, usbev_pkg::OFF_HUB_FCLR)  ? {6'h00, hubFlag_r} :
      hit(addr, usbev_pkg::OFF_IEN_ZERO)  ? {gie_r, 7'h00} :
      hit(addr, usbev_pkg::OFF_IEN_ONE)   ? {4'h0, extPri_r, srEn_r, extLvl_r, extEn_r} :
      hit(addr, usbev_pkg::OFF_PWR_CTL)   ? {4'h0, pwr_r == usbev_pkg::PWR_DOWN, rwu_r, rsmFlag_r, susFlag_r} :
                                            8'h00;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         hubEn_r   <= usbev_pkg::RST_PAIR;
         hubFlag_r <= usbev_pkg::RST_PAIR;
      end
      else
      begin
         if (wrHubEn)
            hubEn_r <= wLow;
         hubFlag_r <= hubFlag_nxt;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         gie_r    <= 1'b0;
         srEn_r   <= 1'b0;
         extEn_r  <= 1'b0;
         extLvl_r <= 1'b0;
         extPri_r <= 1'b0;
      end
      else
      begin
         if (wrIen0)
            gie_r <= wdata[usbev_pkg::B_GIE];
         if (wrIen1)
         begin
            srEn_r   <= wdata[usbev_pkg::B_SR_EN];
            extEn_r  <= wdata[usbev_pkg::B_EXT_EN];
            extLvl_r <= wdata[usbev_pkg::B_EXT_LVL];
            extPri_r <= wdata[usbev_pkg::B_EXT_PRI];
         end
      end
   end

   // status flags: software clears by writing zero, events win
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         susFlag_r <= 1'b0;
         rsmFlag_r <= 1'b0;
         rwu_r     <= 1'b0;
      end
      else
      begin
         susFlag_r <= (wrPwr ? wdata[usbev_pkg::B_SUS] : susFlag_r) || suspEvt;
         rsmFlag_r <= (wrPwr ? wdata[usbev_pkg::B_RSM] : rsmFlag_r) || rsmEvt;
         if (wrPwr)
            rwu_r <= wdata[usbev_pkg::B_RWU];
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pwr_r       <= usbev_pkg::PWR_RUN;
         susp_r      <= 1'b0;
         clkRun_r    <= 1'b1;
         hubSofIrq_r <= 1'b0;
         susResIrq_r <= 1'b0;
         extIrq_r    <= 1'b0;
         rdata_r     <= usbev_pkg::RST_BYTE;
      end
      else
      begin
         pwr_r       <= pwr_nxt;
         susp_r      <= (susp_r || suspEvt) && !link.resumeK && !link.busActive;
         clkRun_r    <= (pwr_nxt != usbev_pkg::PWR_DOWN);
         hubSofIrq_r <= hubReq || sofIrq;
         susResIrq_r <= srReq;
         extIrq_r    <= extReq;
         rdata_r     <= rd ? rdSel : usbev_pkg::RST_BYTE;
      end
   end

   usbev_idle_timer #(
      .IDLE_CYC (IDLE_CYC)
   ) u_idle (
      .clk       (clk),
      .srst      (srst),
      .busActive (link.busActive),
      .idlePulse (idlePulse)
   );

   assign link.wakeK   = rwu_r;
   assign rdata        = rdata_r;
   assign hubSofIrq    = hubSofIrq_r;
   assign susResIrq    = susResIrq_r;
   assign extIrq       = extIrq_r;
   assign coreClkRun   = clkRun_r;
   assign busSuspended = susp_r;
endmodule

/* hw/usbev_host_end.sv */
// upstream end: bus traffic, downstream resume, remote wake detection
module usbev_host_end #(
   parameter int unsigned RESUME_CYC = usbev_pkg::RESUME_CYC
) (
   input  wire logic clk,
   input  wire logic srst,
   usbev_link_if.up  link,
   input  wire logic trafficOn,
   input  wire logic resumeGo,
   output logic      resumeBusy,
   output logic      wakeSeen
);
   localparam int unsigned CW = $clog2(RESUME_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(RESUME_CYC - 1);

   if (RESUME_CYC < 1)
   begin : g_chk
      $error("RESUME_CYC too small");
   end

   logic [CW-1:0] cnt_r;
   logic          busy_r;
   logic          act_r;
   logic          wake_r;
   wire           start = resumeGo && !busy_r;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
         act_r  <= 1'b0;
         wake_r <= 1'b0;
      end
      else
      begin
         if (start)
         begin
            busy_r <= 1'b1;
            cnt_r  <= '0;
         end
         else if (busy_r)
         begin
            cnt_r  <= cnt_r + 1'b1;
            busy_r <= (cnt_r != LAST);
         end
         act_r  <= trafficOn && !busy_r;
         // remote wake-up signalling from the device
         wake_r <= link.wakeK;
      end
   end

   assign link.resumeK   = busy_r;
   assign link.busActive = act_r;
   assign resumeBusy     = busy_r;
   assign wakeSeen       = wake_r;
endmodule

/* dv/usbev_props.sv */
module usbev_props #(
   parameter int unsigned IDLE_CYC = 20
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic busActive,
   input wire logic resumeK,
   input wire logic wakeK,
   input wire logic wakeSeen,
   input wire logic sofIrq,
   input wire logic hubSofIrq,
   input wire logic extIrq,
   input wire logic coreClkRun,
   input wire logic busSuspended
);
   timeunit 1ns;
   timeprecision 1ps;

   int unsigned idleCnt;

   // idle cycles seen on the bus, saturating
   always_ff @(posedge clk)
   begin
      if (srst || busActive)
         idleCnt <= 0;
      else if (idleCnt < 1000)
         idleCnt <= idleCnt + 1;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   long_idle_a: assert property ($rose(busSuspended) |-> idleCnt > IDLE_CYC)
      else $error("suspend before idle limit");
   resume_wake_a: assert property (resumeK && busSuspended |=> !busSuspended && coreClkRun)
      else $error("resume did not end suspend");
   resume_clk_a: assert property (resumeK |=> coreClkRun)
      else $error("clock stopped during resume");
   sof_share_a: assert property (sofIrq |=> hubSofIrq)
      else $error("frame request not merged");
   ext_wake_a: assert property ($rose(extIrq) |-> coreClkRun)
      else $error("external request without clock");
   wake_seen_a: assert property (wakeK [*2] |-> wakeSeen)
      else $error("wake signalling not seen upstream");
   resume_len_a: assert property ($rose(resumeK) |-> resumeK [*8] ##1 resumeK [*2] ##1 !resumeK)
      else $error("resume signalling length wrong");
   quiet_bus_a: assert property (resumeK && $past(resumeK) |-> !busActive)
      else $error("bus active during resume");
endmodule

/* dv/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned IDLE = 20;
   logic       clk = 0;
   logic       srst = 1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr = 0;
   logic       rd = 0;
   logic [3:0] ev = 4'h0;
   logic       sofIrq = 0;
   logic       extIntLvl = 0;
   logic       trafficOn = 1;
   logic       resumeGo = 0;
   logic [7:0] rdata;
   logic [7:0] r;
   logic       hubSofIrq, susResIrq, extIrq, coreClkRun, busSuspended, resumeBusy, wakeSeen;
   int         err_count = 0;
   int         cmp_count = 0;
   int         mf;
   int         mEn = 0;
   int         mFlag = 0;
   int         mGie = 0;
   int         mIen1 = 0;
   int         mPwr = 0;
   logic [7:0] expQ[$];
   usbev_link_if link ();

   usbev_dev_end #(.IDLE_CYC(IDLE)) usbev_dev_end_inst (.clk(clk), .srst(srst), .link(link.dev), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxDoneEvt(ev[1]), .rxFifoErr(ev[3]), .txAckEvt(ev[0]),
      .txFifoErr(ev[2]), .sofIrq(sofIrq), .extIntLvl(extIntLvl), .hubSofIrq(hubSofIrq), .susResIrq(susResIrq),
      .extIrq(extIrq), .coreClkRun(coreClkRun), .busSuspended(busSuspended));
   usbev_host_end #(.RESUME_CYC(10)) usbev_host_end_inst (.clk(clk), .srst(srst), .link(link.up),
      .trafficOn(trafficOn), .resumeGo(resumeGo), .resumeBusy(resumeBusy), .wakeSeen(wakeSeen));
   usbev_props #(.IDLE_CYC(IDLE)) usbev_props_inst (.clk(clk), .srst(srst), .busActive(link.busActive),
      .resumeK(link.resumeK), .wakeK(link.wakeK), .wakeSeen(wakeSeen), .sofIrq(sofIrq), .hubSofIrq(hubSofIrq),
      .extIrq(extIrq), .coreClkRun(coreClkRun), .busSuspended(busSuspended));

   always #12.5 clk = ~clk;

   task automatic results;
      if (err_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // reference model of the register file
   function automatic void mwrite(input logic [7:0] a, input logic [7:0] d);
      case (a)
         usbev_pkg::OFF_HUB_EN:    mEn = d & 8'h03;
         usbev_pkg::OFF_HUB_FLAGS: mFlag = d & 8'h03;
         usbev_pkg::OFF_HUB_FSET:  mFlag = mFlag | (d & 8'h03);
         usbev_pkg::OFF_HUB_FCLR:  mFlag = mFlag & ~(d & 8'h03);
         usbev_pkg::OFF_IEN_ZERO:  mGie = d[usbev_pkg::B_GIE];
         usbev_pkg::OFF_IEN_ONE:   mIen1 = d & 8'h0f;
         usbev_pkg::OFF_PWR_CTL:   mPwr = d & 8'h0f;
      endcase
   endfunction

   function automatic logic [7:0] mval(input logic [7:0] a);
      case (a)
         usbev_pkg::OFF_HUB_EN:    mval = 8'(mEn);
         usbev_pkg::OFF_HUB_FLAGS,
         usbev_pkg::OFF_HUB_FSET,
         usbev_pkg::OFF_HUB_FCLR:  mval = 8'(mFlag);
         usbev_pkg::OFF_IEN_ZERO:  mval = 8'(mGie << usbev_pkg::B_GIE);
         usbev_pkg::OFF_IEN_ONE:   mval = 8'(mIen1);
         usbev_pkg::OFF_PWR_CTL:   mval = 8'(mPwr);
         default:                  mval = 8'h00;
      endcase
   endfunction

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
      mwrite(a, d);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1;
      expQ.push_back(mval(a));
      @(posedge clk);
      rd <= 0;
      #1 chk(rdata, exp);
      chk(rdata, expQ.pop_front());
   endtask

   task automatic waitc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic pulse_resume;
      @(posedge clk);
      resumeGo <= 1;
      @(posedge clk);
      resumeGo <= 0;
   endtask

   initial
   begin
      #100us;
      err_count++;
      results();
   end

   initial
   begin
      void'($urandom(43));
      repeat (5) @(posedge clk);
      srst <= 0;
      rchk(8'h00, 8'h00);
      rchk(8'h01, 8'h00);
      rchk(8'h06, 8'h00);
      rchk(8'h40, 8'h00);
      repeat (4)
      begin
         r = 8'($urandom) & 8'h03;
         wreg(8'h00, r);
         rchk(8'h00, r & 8'h03);
      end
      wreg(8'h00, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         ev[i] <= 1;
         @(posedge clk);
         ev[i] <= 0;
         mf = 1 << (i % 2);
         mFlag = mFlag | mf;
         rchk(8'h01, mf[7:0]);
         wreg(8'h03, mf[7:0]);
         rchk(8'h01, 8'h00);
      end
      wreg(8'h00, 8'h03);
      wreg(8'h01, 8'h02);
      wreg(8'h02, 8'h01);
      rchk(8'h01, 8'h03);
      chk({7'h0, hubSofIrq}, 8'h00);
      wreg(8'h04, 8'h80);
      waitc(2);
      chk({7'h0, hubSofIrq}, 8'h01);
      wreg(8'h00, 8'h00);
      waitc(2);
      chk({7'h0, hubSofIrq}, 8'h00);
      @(posedge clk);
      sofIrq <= 1;
      waitc(2);
      chk({7'h0, hubSofIrq}, 8'h01);
      @(posedge clk);
      sofIrq <= 0;
      wreg(8'h03, 8'h03);
      wreg(8'h05, 8'h04);
      @(posedge clk);
      trafficOn <= 0;
      waitc(IDLE - 2);
      chk({7'h0, busSuspended}, 8'h00);
      waitc(8);
      chk({7'h0, busSuspended}, 8'h01);
      chk({7'h0, susResIrq}, 8'h01);
      mPwr = mPwr | (1 << usbev_pkg::B_SUS);
      rchk(8'h06, 8'h01);
      wreg(8'h06, 8'h00);
      // traffic only once resume runs, else activity ends suspend first
      pulse_resume();
      trafficOn <= 1;
      waitc(4);
      chk({7'h0, busSuspended}, 8'h00);
      chk({7'h0, susResIrq}, 8'h01);
      chk({7'h0, resumeBusy}, 8'h01);
      mPwr = mPwr | (1 << usbev_pkg::B_RSM);
      rchk(8'h06, 8'h02);
      waitc(12);
      wreg(8'h06, 8'h08);
      waitc(2);
      chk({7'h0, coreClkRun}, 8'h00);
      pulse_resume();
      waitc(3);
      chk({7'h0, coreClkRun}, 8'h01);
      mPwr = mPwr & ~(1 << usbev_pkg::B_PD);
      waitc(12);
      wreg(8'h05, 8'h0f);
      wreg(8'h06, 8'h08);
      waitc(2);
      @(posedge clk);
      extIntLvl <= 1;
      waitc(2);
      chk({6'h0, extIrq, coreClkRun}, 8'h03);
      mPwr = mPwr & ~(1 << usbev_pkg::B_PD);
      @(posedge clk);
      extIntLvl <= 0;
      rchk(8'h05, 8'h0f);
      wreg(8'h06, 8'h04);
      waitc(3);
      chk({7'h0, wakeSeen}, 8'h01);
      rchk(8'h06, 8'h04);
      results();
   end
endmodule
